// >>> core/mac_port.sv
// How it works
// - Bit 7 of the interface control register selects reduced mode at 1.
// - With that bit at 0 the port runs as a full-width gigabit interface.
// - The mode bit takes its reset default from the sampled disable strap.
// - The sampled strap stays readable in the strap status register.
// - The receive clock runs at 100, 25 or 2.5 MHz by link speed.
// - Reduced-mode pins are active high but for the falling-edge control level, which is valid XOR error.
// - At gigabit, bits 3:0 go on the rising edge and 7:4 on the falling.
// - Valid/enable and error share one control line, one per edge.
// - A good received frame keeps the receive control line high.
// - Between received frames the receive control line stays low.
// - At 10/100 each nibble is repeated on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module mac_port
	import mac_port_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rstn_in,
	// Strap pin
	input  wire logic        reduced_mode_disable_strap_in,
	// Register port
	input  wire logic [15:0] reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	output logic      [15:0] reg_rdata_out,
	output logic             reg_rvalid_out,
	// Core side
	input  wire logic [1:0]  speed_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic        rx_valid_in,
	input  wire logic        rx_error_in,
	output logic             rx_ready_out,
	output logic      [7:0]  tx_data_out,
	output logic             tx_en_out,
	output logic             tx_er_out,
	output logic             tx_strobe_out,
	output logic             mode_reduced_out,
	// Receive pins
	output logic             rx_clk_out,
	output logic      [3:0]  rgmii_rxd_out,
	output logic             receive_control_line_out,
	output logic      [7:0]  gmii_rxd_out,
	output logic             gmii_rx_dv_out,
	output logic             gmii_rx_er_out,
	// Transmit pins
	input  wire logic        tx_clk_in,
	input  wire logic [3:0]  rgmii_txd_in,
	input  wire logic        transmit_control_line_in,
	input  wire logic [7:0]  gmii_txd_in,
	input  wire logic        gmii_tx_en_in,
	input  wire logic        gmii_tx_er_in
);
	// ************************************************************
	// Registers and strap
	// ************************************************************
	logic [15:0] ctl_reg;
	logic [15:0] strap_status_reg;
	logic        strap_s1_reg;
	logic        strap_s2_reg;
	logic [1:0]  strap_cnt_reg;
	logic        strap_done_reg;
	logic        mode;
	logic        giga;

	assign mode             = ctl_reg[REDUCED_MODE_BIT];
	assign mode_reduced_out = mode;
	assign giga             = speed_in == SPEED_1000;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
		end else begin
			strap_s1_reg <= reduced_mode_disable_strap_in;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	// Strap is caught after release, once the synchroniser has filled
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctl_reg          <= MAC_INTERFACE_CONTROL_RST;
			strap_status_reg <= FIRST_STRAP_STATUS_RST;
			strap_cnt_reg    <= 2'h0;
			strap_done_reg   <= 1'b0;
		end else if (!strap_done_reg) begin
			if (strap_cnt_reg == STRAP_SETTLE) begin
				ctl_reg[REDUCED_MODE_BIT]            <= ~strap_s2_reg;
				strap_status_reg[STRAP_DISABLE_BIT] <= strap_s2_reg;
				strap_done_reg                       <= 1'b1;
			end else begin
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			end
		end else if (reg_write_in &&
			reg_addr_in == MAC_INTERFACE_CONTROL_ADDR) begin
			ctl_reg <= reg_wdata_in;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out  <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_read_in;
			unique case (reg_addr_in)
				MAC_INTERFACE_CONTROL_ADDR: reg_rdata_out <= ctl_reg;
				FIRST_STRAP_STATUS_ADDR:    reg_rdata_out <= strap_status_reg;
				default:                    reg_rdata_out <= 16'h0000;
			endcase
		end
	end

	// ************************************************************
	// Receive clock generation and FIFO
	// ************************************************************
	logic [7:0] half_cnt_reg;
	logic [7:0] half_lim;
	logic       tick;
	logic       rx_rise;
	logic       rx_fall;
	logic [8:0] fifo_data;
	logic       fifo_valid;
	logic       fifo_take;
	logic [8:0] cur_reg;
	logic       cur_valid_reg;
	logic       phase_reg;
	logic       need_new;

	always_comb begin
		unique case (speed_in)
			SPEED_1000: half_lim = 8'(HALF_1000);
			SPEED_100:  half_lim = 8'(HALF_100);
			default:    half_lim = 8'(HALF_10);
		endcase
	end

	assign tick     = half_cnt_reg >= half_lim - 8'h01;
	assign rx_rise  = tick && !rx_clk_out;
	assign rx_fall  = tick && rx_clk_out;
	assign need_new = giga || !phase_reg;
	assign fifo_take = mode ? (rx_rise && need_new) : rx_fall;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			half_cnt_reg <= 8'h00;
			rx_clk_out   <= 1'b0;
		end else if (tick) begin
			half_cnt_reg <= 8'h00;
			rx_clk_out   <= ~rx_clk_out;
		end else begin
			half_cnt_reg <= half_cnt_reg + 8'h01;
		end
	end

	stream_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) rx_fifo (
		.clock_in      (clock_in),
		.rstn_in       (rstn_in),
		.in_data_in    ({rx_error_in, rx_data_in}),
		.in_valid_in   (rx_valid_in),
		.in_ready_out  (rx_ready_out),
		.out_data_out  (fifo_data),
		.out_valid_out (fifo_valid),
		.out_ready_in  (fifo_take)
	);

	// ************************************************************
	// Receive pin encoding
	// ************************************************************
	// An empty FIFO ends the frame, so the core must keep up inside one
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cur_reg                  <= 9'h000;
			cur_valid_reg            <= 1'b0;
			phase_reg                <= 1'b0;
			rgmii_rxd_out            <= 4'h0;
			receive_control_line_out <= 1'b0;
			gmii_rxd_out             <= 8'h00;
			gmii_rx_dv_out           <= 1'b0;
			gmii_rx_er_out           <= 1'b0;
		end else if (!mode) begin
			cur_valid_reg            <= 1'b0;
			phase_reg                <= 1'b0;
			rgmii_rxd_out            <= 4'h0;
			receive_control_line_out <= 1'b0;
			if (rx_fall) begin
				gmii_rxd_out   <= fifo_valid ? fifo_data[7:0] : 8'h00;
				gmii_rx_dv_out <= fifo_valid;
				gmii_rx_er_out <= fifo_valid && fifo_data[RXW_ER];
			end
		end else begin
			gmii_rxd_out   <= 8'h00;
			gmii_rx_dv_out <= 1'b0;
			gmii_rx_er_out <= 1'b0;
			if (rx_rise) begin
				if (need_new) begin
					cur_reg                  <= fifo_data;
					cur_valid_reg            <= fifo_valid;
					phase_reg                <= fifo_valid && !giga;
					rgmii_rxd_out            <= fifo_valid ? fifo_data[3:0]
					                                      : 4'h0;
					receive_control_line_out <= fifo_valid;
				end else begin
					phase_reg                <= 1'b0;
					rgmii_rxd_out            <= cur_reg[7:4];
					receive_control_line_out <= 1'b1;
				end
			end else if (rx_fall) begin
				if (giga) begin
					rgmii_rxd_out <= cur_reg[7:4];
				end
				receive_control_line_out <=
					cur_valid_reg ^ (cur_valid_reg && cur_reg[RXW_ER]);
			end
		end
	end

	// ************************************************************
	// Transmit pin sampling and decoding
	// ************************************************************
	logic [TXS_WIDTH-1:0] txs1_reg;
	logic [TXS_WIDTH-1:0] txs2_reg;
	logic                 tclk_prev_reg;
	logic                 t_rise;
	logic                 t_fall;
	logic                 t_ctl;
	logic [3:0]           t_nib;
	logic [3:0]           nib_reg;
	logic [3:0]           lo_keep_reg;
	logic                 en_lo_reg;
	logic                 er_acc_reg;
	logic                 nib_phase_reg;
	logic                 er_p;

	assign t_rise = txs2_reg[TXS_CLK] && !tclk_prev_reg;
	assign t_fall = !txs2_reg[TXS_CLK] && tclk_prev_reg;
	assign t_ctl  = txs2_reg[TXS_CTL];
	assign t_nib  = txs2_reg[TXS_NIB_H:TXS_NIB_L];
	assign er_p   = en_lo_reg ^ t_ctl;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			txs1_reg      <= '0;
			txs2_reg      <= '0;
			tclk_prev_reg <= 1'b0;
		end else begin
			txs1_reg      <= {tx_clk_in, transmit_control_line_in,
			                  rgmii_txd_in, gmii_tx_en_in, gmii_tx_er_in,
			                  gmii_txd_in};
			txs2_reg      <= txs1_reg;
			tclk_prev_reg <= txs2_reg[TXS_CLK];
		end
	end

	// A stopped MAC clock simply produces no edges and no bytes
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_data_out   <= 8'h00;
			tx_en_out     <= 1'b0;
			tx_er_out     <= 1'b0;
			tx_strobe_out <= 1'b0;
			nib_reg       <= 4'h0;
			lo_keep_reg   <= 4'h0;
			en_lo_reg     <= 1'b0;
			er_acc_reg    <= 1'b0;
			nib_phase_reg <= 1'b0;
		end else begin
			tx_strobe_out <= 1'b0;
			if (!mode) begin
				nib_phase_reg <= 1'b0;
				if (t_rise) begin
					tx_data_out   <= txs2_reg[TXS_BYT_H:TXS_BYT_L];
					tx_en_out     <= txs2_reg[TXS_GEN];
					tx_er_out     <= txs2_reg[TXS_GER];
					tx_strobe_out <= txs2_reg[TXS_GEN] || txs2_reg[TXS_GER];
				end
			end else if (t_rise) begin
				nib_reg   <= t_nib;
				en_lo_reg <= t_ctl;
			end else if (t_fall) begin
				if (giga) begin
					tx_data_out   <= {t_nib, nib_reg};
					tx_en_out     <= en_lo_reg;
					tx_er_out     <= er_p;
					tx_strobe_out <= en_lo_reg || er_p;
				end else if (en_lo_reg || er_p) begin
					if (!nib_phase_reg) begin
						lo_keep_reg   <= nib_reg;
						er_acc_reg    <= er_p;
						nib_phase_reg <= 1'b1;
					end else begin
						tx_data_out   <= {nib_reg, lo_keep_reg};
						tx_en_out     <= en_lo_reg;
						tx_er_out     <= er_acc_reg || er_p;
						tx_strobe_out <= 1'b1;
						nib_phase_reg <= 1'b0;
					end
				end else begin
					nib_phase_reg <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	AST_STRAP_DEFAULT: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		$rose(strap_done_reg) |-> mode == !$past(strap_s2_reg))
		else $error("mode bit did not take the strap default");

	AST_STRAP_KEPT: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		strap_done_reg && $past(strap_done_reg) |-> $stable(strap_status_reg))
		else $error("strap status changed after capture");

	AST_MODE_WRITE: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		strap_done_reg && reg_write_in &&
		reg_addr_in == MAC_INTERFACE_CONTROL_ADDR
		|=> mode == $past(reg_wdata_in[REDUCED_MODE_BIT]))
		else $error("mode bit did not follow the write");

	AST_FULL_WIDTH_QUIET: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		!mode && !$past(mode) |-> !receive_control_line_out &&
		rgmii_rxd_out == 4'h0)
		else $error("reduced pins active in full-width mode");

	AST_RX_IDLE_LOW: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		mode && !cur_valid_reg |-> !receive_control_line_out)
		else $error("receive control high outside a frame");

	AST_RX_GOOD_HIGH: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		mode && rx_fall && cur_valid_reg && !cur_reg[RXW_ER]
		|=> receive_control_line_out)
		else $error("receive control low in a good frame");

	AST_RX_REPEAT: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		mode && rx_fall && !giga |=> $stable(rgmii_rxd_out))
		else $error("nibble not repeated at falling edge");

	AST_RX_CLK_100: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		$rose(rx_clk_out) && speed_in == SPEED_100 ##1
		(speed_in == SPEED_100) [*3]
		|-> rx_clk_out && $past(rx_clk_out) && $past(rx_clk_out, 2)
		##1 !rx_clk_out)
		else $error("100 Mb/s receive clock high time wrong");

	AST_TX_BYTE: assert property (@(posedge clock_in)
		disable iff (!rstn_in)
		mode && giga && t_fall && (en_lo_reg || t_ctl)
		|=> tx_strobe_out && tx_data_out[7:4] == $past(t_nib) &&
		tx_er_out == ($past(en_lo_reg) ^ $past(t_ctl)))
		else $error("gigabit byte or error decode wrong");
endmodule // mac_port
`default_nettype wire

// >>> core/mac_port_pkg.sv
package mac_port_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [15:0] MAC_INTERFACE_CONTROL_ADDR = 16'h0032;
	localparam logic [15:0] FIRST_STRAP_STATUS_ADDR    = 16'h0040;
	localparam int          REDUCED_MODE_BIT           = 7;
	localparam int          STRAP_DISABLE_BIT          = 0;
	localparam logic [15:0] MAC_INTERFACE_CONTROL_RST  = 16'h0000;
	localparam logic [15:0] FIRST_STRAP_STATUS_RST     = 16'h0000;
	localparam logic [1:0]  STRAP_SETTLE               = 2'h3;

	// ************************************************************
	// Speeds and interface clock timing
	// ************************************************************
	localparam logic [1:0] SPEED_10   = 2'h0;
	localparam logic [1:0] SPEED_100  = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	localparam int CLOCK_FREQ_KHZ   = 200000;
	localparam int RX_FREQ_1000_KHZ = 125000;
	localparam int RX_FREQ_100_KHZ  = 25000;
	localparam int RX_FREQ_10_KHZ   = 2500;

	function automatic int half_cycles(input int freq_khz);
		int n;
		n = CLOCK_FREQ_KHZ / (2 * freq_khz);
		return (n < 1) ? 1 : n;
	endfunction

	localparam int HALF_1000 = half_cycles(RX_FREQ_1000_KHZ);
	localparam int HALF_100  = half_cycles(RX_FREQ_100_KHZ);
	localparam int HALF_10   = half_cycles(RX_FREQ_10_KHZ);

	// ************************************************************
	// Transmit pin sampling vector layout
	// ************************************************************
	localparam int TXS_WIDTH = 16;
	localparam int TXS_CLK   = 15;
	localparam int TXS_CTL   = 14;
	localparam int TXS_NIB_H = 13;
	localparam int TXS_NIB_L = 10;
	localparam int TXS_GEN   = 9;
	localparam int TXS_GER   = 8;
	localparam int TXS_BYT_H = 7;
	localparam int TXS_BYT_L = 0;

	// Receive FIFO word: error flag above the byte
	localparam int RXW_ER = 8;
endpackage

// >>> core/stream_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module stream_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clock_in,
	input  wire logic             rstn_in,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	// Drain side
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	// Pointer wrap relies on a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
		$error("stream_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;

	assign in_ready_out  = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
	assign out_valid_out = wr_ptr_reg != rd_ptr_reg;
	assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // stream_fifo
`default_nettype wire

// >>> verification/mac_model.sv
`timescale 1ns/100ps
`default_nettype none
module mac_model
	import mac_port_pkg::*;
(
	// Reduced transmit pins
	output logic       tx_clk_out,
	output logic [3:0] txd_out,
	output logic       tx_ctl_out,
	// Full-width transmit pins
	output logic [7:0] gmii_txd_out,
	output logic       gmii_en_out,
	output logic       gmii_er_out
);
	// ****************
	// Link timing
	// ****************
	// Quarter of the 125 ns link period; data moves between clock edges
	localparam realtime QTR = 31.25;

	initial begin
		tx_clk_out = 1'b0;
		txd_out = 4'h5;
		tx_ctl_out = 1'b0;
		gmii_txd_out = 8'ha5;
		gmii_en_out = 1'b0;
		gmii_er_out = 1'b0;
	end

	// One link period: a and ca for the rise, b and cb for the fall
	task automatic period(input logic [3:0] a, input logic [3:0] b,
		input logic ca, input logic cb);
		txd_out = a;
		tx_ctl_out = ca;
		#QTR tx_clk_out = 1'b1;
		#QTR txd_out = b;
		tx_ctl_out = cb;
		#QTR tx_clk_out = 1'b0;
		#QTR;
	endtask

	task automatic send(input logic [7:0] d, input logic er,
		input logic [1:0] spd, input logic red);
		if (!red) begin
			gmii_txd_out = d;
			gmii_en_out = 1'b1;
			gmii_er_out = er;
			period(txd_out, ~txd_out, 1'b0, 1'b0);
		end else if (spd == SPEED_1000) begin
			period(d[3:0], d[7:4], 1'b1, ~er);
		end else begin
			period(d[3:0], d[3:0], 1'b1, ~er);
			period(d[7:4], d[7:4], 1'b1, ~er);
		end
	endtask

	// Clock stands low between frames; released data lines wander
	task automatic idle();
		tx_ctl_out = 1'b0;
		gmii_en_out = 1'b0;
		gmii_er_out = 1'b0;
		txd_out = ~txd_out;
		gmii_txd_out = ~gmii_txd_out;
	endtask
endmodule // mac_model
`default_nettype wire

// >>> verification/test_rgmii_gmii_mac_port.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin \
	total_checks++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("mismatch %s expected %h seen %h", what, exp, got); \
	end \
end
module test_rgmii_gmii_mac_port
	import mac_port_pkg::*;
;
	// ****************
	// Signals
	// ****************
	logic        clock_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        strap = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [1:0]  speed = SPEED_1000;
	logic [7:0]  rxd = 8'h00;
	logic        rxv = 1'b0;
	logic        rxe = 1'b0;
	logic        red = 1'b1;
	logic        rclk_prev = 1'b0;
	logic        rise_ctl = 1'b0;
	logic        half = 1'b0;
	logic        e0 = 1'b0;
	logic [15:0] rdata, e16;
	logic        rvalid, rx_ready, tx_en, tx_er, tx_stb, mode;
	logic [7:0]  tx_data, gmii_rxd, gtxd;
	logic [3:0]  rgmii_rxd, ttxd, rise_nib, lo;
	logic        rx_clk, rx_ctl, g_dv, g_er, tclk, tctl, gen, ger;
	logic [8:0]  e9;
	logic [9:0]  e10;
	logic [31:0] seed = 32'h48576b03;
	logic [31:0] v;
	logic [9:0]  q_tx[$];
	logic [8:0]  q_rx[$];
	logic [15:0] q_rd[$];
	int          bad_count = 0;
	int          total_checks = 0;
	int          refused = 0;

	always #2.5 clock_in = ~clock_in;

	mac_model mac (
		.tx_clk_out(tclk), .txd_out(ttxd), .tx_ctl_out(tctl),
		.gmii_txd_out(gtxd), .gmii_en_out(gen), .gmii_er_out(ger)
	);
	mac_port #(.FIFO_DEPTH(16)) uut (
		.clock_in(clock_in), .rstn_in(rstn_in),
		.reduced_mode_disable_strap_in(strap),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
		.reg_read_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.speed_in(speed), .rx_data_in(rxd), .rx_valid_in(rxv),
		.rx_error_in(rxe), .rx_ready_out(rx_ready), .tx_data_out(tx_data),
		.tx_en_out(tx_en), .tx_er_out(tx_er), .tx_strobe_out(tx_stb),
		.mode_reduced_out(mode), .rx_clk_out(rx_clk),
		.rgmii_rxd_out(rgmii_rxd), .receive_control_line_out(rx_ctl),
		.gmii_rxd_out(gmii_rxd), .gmii_rx_dv_out(g_dv),
		.gmii_rx_er_out(g_er), .tx_clk_in(tclk), .rgmii_txd_in(ttxd),
		.transmit_control_line_in(tctl), .gmii_txd_in(gtxd),
		.gmii_tx_en_in(gen), .gmii_tx_er_in(ger)
	);

	// ****************
	// Drivers
	// ****************
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic do_reset(input logic s);
		@(negedge clock_in);
		strap = s;
		rstn_in = 1'b0;
		repeat (2) @(negedge clock_in);
		rstn_in = 1'b1;
		repeat (8) @(negedge clock_in);
	endtask

	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clock_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock_in);
		wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
		@(negedge clock_in);
		addr = a;
		rd = 1'b1;
		q_rd.push_back(e);
		@(negedge clock_in);
		rd = 1'b0;
	endtask

	task automatic tx_byte(input logic e);
		logic [31:0] r;
		r = rnd();
		q_tx.push_back({r[7:0], 1'b1, e});
		mac.send(r[7:0], e, speed, red);
	endtask

	// Pushes back to back; a full buffer holds the byte until it drains
	task automatic push_rx();
		logic [31:0] r;
		r = rnd();
		@(negedge clock_in);
		rxd = r[7:0];
		rxe = r[8];
		rxv = 1'b1;
		while (rx_ready !== 1'b1) begin
			refused++;
			@(negedge clock_in);
		end
		q_rx.push_back(r[8:0]);
		@(posedge clock_in);
	endtask

	task automatic traffic(input int n);
		fork
			begin
				for (int i = 0; i < 4; i++)
					tx_byte(i == 2);
				mac.idle();
			end
			begin
				for (int i = 0; i < n; i++)
					push_rx();
				@(negedge clock_in);
				rxv = 1'b0;
			end
		join
	endtask

	task automatic drain(input string name);
		int n;
		n = 0;
		while (q_tx.size() + q_rx.size() + q_rd.size() != 0 && n < 4000) begin
			@(negedge clock_in);
			n++;
		end
		if (n == 4000) begin
			bad_count++;
			$display("mismatch %s expected drained seen pending", name);
		end
		repeat (8) @(negedge clock_in);
		$display("test %s done", name);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************
	// Output watcher
	// ****************
	task automatic rx_got(input logic [8:0] got);
		e9 = (q_rx.size() != 0) ? q_rx.pop_front() : 'x;
		`CHK("rx byte", e9, got)
	endtask

	always @(negedge clock_in) begin
		if (!rstn_in)
			half = 1'b0;
		if (rvalid === 1'b1) begin
			e16 = (q_rd.size() != 0) ? q_rd.pop_front() : 'x;
			`CHK("reg read", e16, rdata)
		end
		if (tx_stb === 1'b1) begin
			e10 = (q_tx.size() != 0) ? q_tx.pop_front() : 'x;
			`CHK("tx byte", e10, {tx_data, tx_en, tx_er})
		end
		if (rx_clk === 1'b1 && rclk_prev === 1'b0) begin
			rise_nib = rgmii_rxd;
			rise_ctl = rx_ctl;
			if (!red && g_dv === 1'b1)
				rx_got({g_er, gmii_rxd});
		end
		if (rx_clk === 1'b0 && rclk_prev === 1'b1 && red) begin
			if (rise_ctl !== 1'b1)
				`CHK("idle ctl", 1'b0, rx_ctl)
			else if (speed == SPEED_1000)
				rx_got({~rx_ctl, rgmii_rxd, rise_nib});
			else begin
				`CHK("repeat", rise_nib, rgmii_rxd)
				if (half)
					rx_got({e0 | ~rx_ctl, rise_nib, lo});
				lo = rise_nib;
				e0 = ~rx_ctl;
				half = ~half;
			end
		end
		rclk_prev = rx_clk;
	end

	// ****************
	// Tests
	// ****************
	initial begin
		do_reset(1'b0);
		`CHK("mode", 1'b1, mode)
		reg_rd(MAC_INTERFACE_CONTROL_ADDR, 16'h0080);
		reg_wr(FIRST_STRAP_STATUS_ADDR, 16'hffff);
		reg_rd(FIRST_STRAP_STATUS_ADDR, 16'h0000);
		reg_rd(16'h0010, 16'h0000);
		v = rnd() | 32'h0080;
		reg_wr(MAC_INTERFACE_CONTROL_ADDR, v[15:0]);
		reg_rd(MAC_INTERFACE_CONTROL_ADDR, v[15:0]);
		drain("registers");
		for (int s = 2; s >= 0; s--) begin
			speed = s[1:0];
			repeat (100) @(negedge clock_in);
			traffic(s == 2 ? 40 : 6);
			drain("reduced");
		end
		red = 1'b0;
		speed = SPEED_1000;
		reg_wr(MAC_INTERFACE_CONTROL_ADDR, 16'h0000);
		`CHK("mode", 1'b0, mode)
		traffic(8);
		drain("full width");
		do_reset(1'b1);
		reg_rd(MAC_INTERFACE_CONTROL_ADDR, 16'h0000);
		reg_wr(MAC_INTERFACE_CONTROL_ADDR, 16'h0080);
		`CHK("mode", 1'b1, mode)
		reg_rd(FIRST_STRAP_STATUS_ADDR, 16'h0001);
		drain("strap");
		`CHK("refusals", 1'b1, refused > 0)
		wrap_up();
	end

	initial begin
		#200000;
		bad_count++;
		$display("mismatch watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule // test_rgmii_gmii_mac_port
`default_nettype wire
